// ===== hdl/count_events_if.sv
// decoded input events passed from an edge decoder to its channel
`timescale 1ns/1ps
interface count_events_if;
  logic a_evt;
  logic b_evt;
  logic step_up;
  logic step_down;
  modport src (output a_evt, b_evt, step_up, step_down);
  modport dst (input a_evt, b_evt, step_up, step_down);
endinterface

// ===== hdl/counter_pkg.sv
// constants, types and operation overview for the four-channel counter
// Overview of operation
// R1 - four identical channels, each independently set to one of nine modes incl. test
// R2 - A input used by all modes but test; B only in up-down, interval, ratio
// R3 - up-down decodes separate up/down pulses, count plus direction, or quadrature
// R4 - each channel counts on rising or falling input edges, selectable
// R5 - period, frequency, interval, prescale, ratio run back to back or wait for start
// R6 - overflow, underflow and completion interrupts, each individually enabled
// R7 - prescale counts down from preset, interrupts at zero, reloads and continues
// R8 - up-down count spans -32768..32767 and wraps to zero past either end
// R9 - totalize and prescale span 0..32767; totalize wraps to -32768 past maximum
// R10 - extended totalize is 32-bit, read as two words, wraps to most negative
// R11 - read-and-restart captures count and restarts in one cycle, no edge lost
// R12 - period and interval average over 1 to 32767 periods or intervals
// R13 - period and interval range 1..6 picks resolution 100 ms down to 1 us
// R14 - frequency range 1..6 picks gate 1000 s down to 10 ms, counting A edges
// R15 - ratio counts A cycles during a gate of programmed B cycles
// R16 - measurement start may be paced by a start event
// R17 - commands start, stop and continue counting from the held value
// R18 - totalize and up-down accept a start preset anywhere in range
// R19 - quadrature counts up when A leads B, down when B leads; double changes ignored
package counter_pkg;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 32;
  localparam int WORD_W = 16;
  localparam int RANGE_W = 3;
  localparam int IRQ_W = 3;
  localparam int DECADES = 10;
  localparam int DEC_W = 4;
  localparam int IDX_W = 4;

  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W = 7;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [DEC_W-1:0] DEC_LAST = 4'h9;

  localparam logic [RANGE_W-1:0] RANGE_MIN = 3'h1;
  localparam logic [RANGE_W-1:0] RANGE_MAX = 3'h6;
  localparam logic [IDX_W-1:0] RES_BASE = 4'h6;
  localparam logic [IDX_W-1:0] GATE_BASE = 4'ha;
  localparam logic [IDX_W-1:0] GATE_IDX_RST = 4'h9;

  localparam logic [WORD_W-1:0] WORD_MAX = 16'h7fff;
  localparam logic [WORD_W-1:0] WORD_MIN = 16'h8000;
  localparam logic [CNT_W-1:0] DWORD_MAX = 32'h7fffffff;
  localparam logic [WORD_W-1:0] AVG_RST = 16'h0001;

  localparam int IRQ_OVF = 0;
  localparam int IRQ_UNF = 1;
  localparam int IRQ_DONE = 2;

  typedef enum logic [3:0] {
    MODE_PRESCALE = 4'h0,
    MODE_TOTALIZE = 4'h1,
    MODE_EXTENDED = 4'h2,
    MODE_UPDOWN = 4'h3,
    MODE_PERIOD = 4'h4,
    MODE_INTERVAL = 4'h5,
    MODE_FREQUENCY = 4'h6,
    MODE_RATIO = 4'h7,
    MODE_TEST = 4'h8
  } mode_e;

  typedef enum logic [1:0] {
    UD_SEPARATE = 2'h0,
    UD_DIRECTION = 2'h1,
    UD_QUADRATURE = 2'h2
  } updown_e;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_START = 3'h1,
    CMD_STOP = 3'h2,
    CMD_CONTINUE = 3'h3,
    CMD_READ_RESTART = 3'h4
  } cmd_e;

  typedef enum logic [1:0] {
    ST_STOP = 2'h0,
    ST_SYNC = 2'h1,
    ST_RUN = 2'h2,
    ST_GAP = 2'h3
  } chan_state_e;
endpackage

// ===== hdl/decade_timebase.sv
// decade timebase: one-cycle strobes every 1 us up to every 1000 s
`timescale 1ns/1ps
module decade_timebase (
  input wire logic clk,
  input wire logic rst,
  output logic [counter_pkg::DECADES-1:0] tick
);
  import counter_pkg::*;

  logic [TICK_W-1:0] pre_q;
  logic [DECADES-1:0] carry;

  assign carry[0] = pre_q == TICK_LAST;

  always_ff @(posedge clk) begin
    if (rst || carry[0]) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + TICK_W'(1);
    end
  end

  // one decade stage per generate entry, each dividing by ten
  for (genvar k = 1; k < DECADES; k++) begin : g_dec
    logic [DEC_W-1:0] dec_q;
    assign carry[k] = carry[k-1] & (dec_q == DEC_LAST);
    always_ff @(posedge clk) begin
      if (rst || carry[k]) begin
        dec_q <= '0;
      end else if (carry[k-1]) begin
        dec_q <= dec_q + DEC_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    tick <= rst ? '0 : carry;
  end
endmodule

// ===== hdl/input_edge_decode.sv
// input synchroniser, edge select and up-down decoding for one channel
`timescale 1ns/1ps
module input_edge_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic falling,
  input wire counter_pkg::updown_e ud_type,
  count_events_if.src ev
);
  import counter_pkg::*;

  // bit 0 is A, bit 1 is B
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= {pin_b, pin_a};
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  wire logic [1:0] rise = sync_q & ~last_q;
  wire logic [1:0] fall = ~sync_q & last_q;
  wire logic [1:0] edge_sel = falling ? fall : rise; // [R4]
  wire logic both_chg = &(sync_q ^ last_q);
  wire logic a_e = edge_sel[0];
  wire logic b_e = edge_sel[1];
  // on A's active edge, B still at its idle level means A is leading
  wire logic b_idle = sync_q[1] == falling;
  wire logic q_up = a_e & ~both_chg & b_idle; // [R19]
  wire logic q_dn = a_e & ~both_chg & ~b_idle; // [R19]
  wire logic s_up = a_e & ~b_e;
  wire logic s_dn = b_e & ~a_e;
  wire logic d_up = a_e & ~sync_q[1];
  wire logic d_dn = a_e & sync_q[1];

  assign ev.a_evt = a_e;
  assign ev.b_evt = b_e;
  assign ev.step_up = (ud_type == UD_QUADRATURE) ? q_up :
                      (ud_type == UD_DIRECTION) ? d_up : s_up; // [R3]
  assign ev.step_down = (ud_type == UD_QUADRATURE) ? q_dn :
                        (ud_type == UD_DIRECTION) ? d_dn : s_dn; // [R3]
endmodule

// ===== hdl/quad_multimode_counter.sv
// four-channel multimode counter: configuration, commands and count engines
`timescale 1ns/1ps
module quad_multimode_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [counter_pkg::NUM_CH-1:0] pin_a,
  input wire logic [counter_pkg::NUM_CH-1:0] pin_b,
  input wire logic [counter_pkg::NUM_CH-1:0] cfg_full_wr,
  input wire logic [counter_pkg::NUM_CH-1:0] cfg_func_wr,
  input wire logic [counter_pkg::NUM_CH-1:0] cfg_avg_wr,
  input wire counter_pkg::mode_e cfg_mode,
  input wire logic [counter_pkg::RANGE_W-1:0] cfg_range,
  input wire counter_pkg::updown_e cfg_updown,
  input wire logic cfg_falling,
  input wire logic cfg_wait_start,
  input wire logic [counter_pkg::IRQ_W-1:0] cfg_int_en,
  input wire logic [counter_pkg::CNT_W-1:0] cfg_preset,
  input wire logic [counter_pkg::WORD_W-1:0] cfg_average,
  input wire logic [counter_pkg::NUM_CH-1:0] cmd_valid,
  input wire counter_pkg::cmd_e cmd,
  output logic [counter_pkg::CNT_W-1:0] count_value [counter_pkg::NUM_CH],
  output logic [counter_pkg::CNT_W-1:0] read_value [counter_pkg::NUM_CH],
  output logic [counter_pkg::CNT_W-1:0] result_value [counter_pkg::NUM_CH],
  output logic [counter_pkg::NUM_CH-1:0] result_fresh,
  output logic [counter_pkg::NUM_CH-1:0] running,
  output logic [counter_pkg::IRQ_W-1:0] irq [counter_pkg::NUM_CH],
  output counter_pkg::mode_e mode_read [counter_pkg::NUM_CH],
  output logic [counter_pkg::RANGE_W-1:0] range_read [counter_pkg::NUM_CH],
  output logic [counter_pkg::WORD_W-1:0] average_read [counter_pkg::NUM_CH]
);
  import counter_pkg::*;

  logic [DECADES-1:0] tick;

  // one shared timebase keeps all channels on the same resolution grid
  decade_timebase u_tb (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  wire logic cmd_go = cmd == CMD_START;
  wire logic cmd_halt = cmd == CMD_STOP;
  wire logic cmd_resume = cmd == CMD_CONTINUE;
  wire logic cmd_rr = cmd == CMD_READ_RESTART;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch // [R1]
    // configuration held per channel
    mode_e mode_q;
    updown_e ud_q;
    logic fall_q;
    logic wait_q;
    logic [RANGE_W-1:0] rng_q;
    logic [IRQ_W-1:0] ien_q;
    logic [CNT_W-1:0] preset_q;
    logic [WORD_W-1:0] avg_q;

    // channel state
    chan_state_e st_q;
    chan_state_e st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [WORD_W-1:0] aux_q;
    logic [WORD_W-1:0] aux_d;
    logic [CNT_W-1:0] res_q;
    logic [CNT_W-1:0] res_d;
    logic [CNT_W-1:0] rd_q;
    logic [CNT_W-1:0] rd_d;
    logic [IRQ_W-1:0] evt_d;
    logic [IRQ_W-1:0] irq_q;
    logic fresh_q;

    count_events_if ev ();

    input_edge_decode u_dec (
      .clk(clk),
      .rst(rst),
      .pin_a(pin_a[i]),
      .pin_b(pin_b[i]),
      .falling(fall_q),
      .ud_type(ud_q),
      .ev(ev)
    );

    // command and configuration strobes for this channel
    wire logic go = cmd_valid[i] & cmd_go;
    wire logic halt = cmd_valid[i] & cmd_halt;
    wire logic resume = cmd_valid[i] & cmd_resume;
    wire logic rr = cmd_valid[i] & cmd_rr;
    wire logic cfg_hit = cfg_full_wr[i] | cfg_func_wr[i];

    // mode classes
    wire logic is_pre = mode_q == MODE_PRESCALE;
    wire logic is_ext = mode_q == MODE_EXTENDED;
    wire logic is_per = mode_q == MODE_PERIOD;
    wire logic is_int = mode_q == MODE_INTERVAL;
    wire logic is_frq = mode_q == MODE_FREQUENCY;
    wire logic is_rat = mode_q == MODE_RATIO;
    wire logic is_meas = is_per | is_int | is_frq | is_rat;
    wire logic paced = wait_q & (is_meas | is_pre); // [R5]

    // timebase selection from the decade range
    wire logic rng_ok = (rng_q >= RANGE_MIN) && (rng_q <= RANGE_MAX);
    wire logic [IDX_W-1:0] res_idx = rng_ok ? RES_BASE - {1'b0, rng_q} : '0; // [R13]
    wire logic [IDX_W-1:0] gate_idx = rng_ok ? GATE_BASE - {1'b0, rng_q} : GATE_IDX_RST; // [R14]
    wire logic res_tick = tick[res_idx];
    wire logic gate_tick = tick[gate_idx];

    // B is only looked at by up-down (via the decoder), interval and ratio
    wire logic sync_evt = is_frq ? gate_tick : (is_rat ? ev.b_evt : ev.a_evt); // [R2]
    wire logic minc = (is_per | is_int) ? res_tick : ev.a_evt; // [R13] [R14]
    wire logic end_evt = is_frq ? gate_tick : ((is_int | is_rat) ? ev.b_evt : ev.a_evt); // [R15]
    wire logic cstep = (mode_q == MODE_TEST) ? tick[0] : ev.a_evt;

    // averaging over N periods, N of zero treated as one
    wire logic [WORD_W-1:0] navg = (avg_q == '0) ? AVG_RST : avg_q;
    wire logic [WORD_W-1:0] aux_inc = aux_q + WORD_W'(1);
    wire logic fin = is_frq | (aux_inc >= navg); // [R12] [R15]
    wire chan_state_e again_st = is_int ? ST_SYNC : ST_RUN;

    // restart value: the same cycle's edge is applied on top of it
    wire logic [CNT_W-1:0] rbase = is_pre ? {16'h0, preset_q[WORD_W-1:0]} : '0;
    wire logic [CNT_W-1:0] base = rr ? rbase : cnt_q; // [R11]
    wire logic [WORD_W-1:0] lo = base[WORD_W-1:0];
    wire logic [CNT_W-1:0] load_val = is_ext ? preset_q : {16'h0, preset_q[WORD_W-1:0]}; // [R18]
    wire chan_state_e start_st = is_meas ? ST_SYNC : ST_RUN;

    always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      aux_d = aux_q;
      res_d = res_q;
      rd_d = rd_q;
      evt_d = '0;
      if (rr) begin
        rd_d = cnt_q; // [R11]
        cnt_d = rbase;
      end
      unique case (st_q)
        ST_STOP: begin
        end
        ST_SYNC: begin
          if (sync_evt) begin // [R16]
            st_d = ST_RUN;
            cnt_d = '0;
            aux_d = '0;
          end
        end
        ST_GAP: begin
          if (ev.a_evt) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          unique case (mode_q)
            MODE_PRESCALE: begin
              if (ev.a_evt) begin
                if (lo <= 16'h1) begin
                  cnt_d = rbase; // [R7]
                  evt_d[IRQ_DONE] = 1'b1;
                  if (paced) begin
                    st_d = ST_STOP;
                  end
                end else begin
                  cnt_d = {16'h0, lo - 16'h1}; // [R7]
                end
              end
            end
            MODE_TOTALIZE, MODE_TEST: begin
              if (cstep) begin
                cnt_d = {16'h0, lo + 16'h1}; // [R9]
                evt_d[IRQ_OVF] = lo == WORD_MAX;
              end
            end
            MODE_EXTENDED: begin
              if (ev.a_evt) begin
                cnt_d = base + CNT_W'(1); // [R10]
                evt_d[IRQ_OVF] = base == DWORD_MAX;
              end
            end
            MODE_UPDOWN: begin
              if (ev.step_up) begin
                cnt_d = (lo == WORD_MAX) ? '0 : {16'h0, lo + 16'h1}; // [R8]
                evt_d[IRQ_OVF] = lo == WORD_MAX;
              end else if (ev.step_down) begin
                cnt_d = (lo == WORD_MIN) ? '0 : {16'h0, lo - 16'h1}; // [R8]
                evt_d[IRQ_UNF] = lo == WORD_MIN;
              end
            end
            MODE_PERIOD, MODE_INTERVAL, MODE_FREQUENCY, MODE_RATIO: begin
              cnt_d = base + {31'h0, minc};
              evt_d[IRQ_OVF] = minc & (&base);
              if (end_evt) begin
                aux_d = aux_inc;
                if (fin) begin
                  res_d = cnt_d; // [R12]
                  cnt_d = '0;
                  aux_d = '0;
                  evt_d[IRQ_DONE] = 1'b1;
                  st_d = paced ? ST_STOP : again_st; // [R5]
                end else if (is_int) begin
                  st_d = ST_GAP;
                end
              end
            end
            default: begin
            end
          endcase
        end
      endcase
      // reconfiguring stops the channel; commands come after the count engine
      if (cfg_hit) begin
        st_d = ST_STOP;
      end else if (go) begin
        st_d = start_st; // [R17] [R16]
        cnt_d = is_meas ? '0 : load_val;
        aux_d = '0;
      end else if (halt) begin
        st_d = ST_STOP; // [R17]
      end else if (resume && st_q == ST_STOP) begin
        st_d = ST_RUN; // [R17]
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        st_q <= ST_STOP;
        cnt_q <= '0;
        aux_q <= '0;
        res_q <= '0;
        rd_q <= '0;
      end else begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        aux_q <= aux_d;
        res_q <= res_d;
        rd_q <= rd_d;
      end
    end

    // completion sets the fresh flag even when a start clears it the same cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        irq_q <= '0;
        fresh_q <= 1'b0;
      end else begin
        irq_q <= evt_d & ien_q; // [R6]
        fresh_q <= evt_d[IRQ_DONE] | (fresh_q & ~go);
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        mode_q <= MODE_TOTALIZE;
        rng_q <= RANGE_MIN;
      end else if (cfg_hit) begin
        mode_q <= cfg_mode;
        rng_q <= cfg_range;
      end
    end

    // the full configure also loads edge, decoding, pacing, interrupts, preset
    always_ff @(posedge clk) begin
      if (rst) begin
        ud_q <= UD_SEPARATE;
        fall_q <= 1'b0;
        wait_q <= 1'b0;
        ien_q <= '0;
        preset_q <= '0;
      end else if (cfg_full_wr[i]) begin
        ud_q <= cfg_updown;
        fall_q <= cfg_falling;
        wait_q <= cfg_wait_start;
        ien_q <= cfg_int_en;
        preset_q <= cfg_preset;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        avg_q <= AVG_RST;
      end else if (cfg_avg_wr[i] || cfg_full_wr[i]) begin
        avg_q <= cfg_average;
      end
    end

    assign count_value[i] = cnt_q;
    assign read_value[i] = rd_q;
    assign result_value[i] = res_q;
    assign result_fresh[i] = fresh_q;
    assign running[i] = st_q != ST_STOP;
    assign irq[i] = irq_q;
    assign mode_read[i] = mode_q;
    assign range_read[i] = rng_q;
    assign average_read[i] = avg_q;
  end
endmodule

// ===== test/counter_monitor.sv
// port assertions for channel 0 of the counter
`timescale 1ns/1ps
module counter_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic [counter_pkg::NUM_CH-1:0] cfg_full_wr,
  input wire logic [counter_pkg::NUM_CH-1:0] cfg_func_wr,
  input wire counter_pkg::mode_e cfg_mode,
  input wire logic [counter_pkg::NUM_CH-1:0] cmd_valid,
  input wire counter_pkg::cmd_e cmd,
  input wire logic [counter_pkg::CNT_W-1:0] count_value [counter_pkg::NUM_CH],
  input wire logic [counter_pkg::CNT_W-1:0] read_value [counter_pkg::NUM_CH],
  input wire logic [counter_pkg::NUM_CH-1:0] running,
  input wire counter_pkg::mode_e mode_read [counter_pkg::NUM_CH]
);
  import counter_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] lo;
  logic steady;
  logic short_mode;
  assign lo = count_value[0][15:0];
  // commands and config writes may legally reload the count, so wraps are judged without them
  assign steady = running[0] && !cmd_valid[0] && !cfg_full_wr[0] && !cfg_func_wr[0];
  assign short_mode = mode_read[0] inside {MODE_PRESCALE, MODE_TOTALIZE, MODE_UPDOWN};
  sequence s_cmd(c);
    cmd_valid[0] && cmd == c && !cfg_full_wr[0] && !cfg_func_wr[0];
  endsequence
  sequence s_held;
    steady ##1 steady;
  endsequence
  AST_START: assert property (s_cmd(CMD_START) |=> running[0])
    else $error("start did not run the channel");
  AST_STOP: assert property (s_cmd(CMD_STOP) |=> !running[0])
    else $error("stop did not halt the channel");
  AST_CONTINUE: assert property (s_cmd(CMD_CONTINUE) ##0 !running[0] |=> running[0])
    else $error("continue did not resume");
  AST_CFG_STOPS: assert property (cfg_full_wr[0] |=> !running[0] && mode_read[0] == $past(cfg_mode))
    else $error("full configure not taken");
  AST_READ_CAPTURE: assert property (s_cmd(CMD_READ_RESTART) ##0 running[0]
    |=> read_value[0] == $past(count_value[0]))
    else $error("captured count differs");
  AST_UD_TOP: assert property (s_held ##0 (mode_read[0] == MODE_UPDOWN && $past(lo) == 16'h7fff)
    |-> lo inside {16'h7fff, 16'h7ffe, 16'h0000})
    else $error("up-down top wrap not to zero");
  AST_UD_BOTTOM: assert property (s_held ##0 (mode_read[0] == MODE_UPDOWN && $past(lo) == 16'h8000)
    |-> lo inside {16'h8000, 16'h8001, 16'h0000})
    else $error("up-down bottom wrap not to zero");
  AST_TOT_WRAP: assert property (s_held ##0 (mode_read[0] == MODE_TOTALIZE && $past(lo) == 16'h7fff)
    |-> lo inside {16'h7fff, 16'h8000})
    else $error("totalize wrap wrong");
  AST_PRESCALE_NZ: assert property (s_held ##0 mode_read[0] == MODE_PRESCALE |-> lo != 16'h0000)
    else $error("prescale showed zero");
  AST_HI_ZERO: assert property (s_held ##0 short_mode |-> count_value[0][31:16] == 16'h0000)
    else $error("upper word set in short mode");
endmodule

// ===== test/pulse_source.sv
// sensor model: pulse trains, direction level and quadrature on one A/B pair
`timescale 1ns/1ps
module pulse_source #(
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] style,
  input wire logic [7:0] n,
  output logic a,
  output logic b,
  output logic busy
);
  initial begin
    a = 1'b0;
    b = 1'b0;
    busy = 1'b0;
  end
  // min_pulse_width and min_pulse_gap shrunk to HALF clocks, still above the synchroniser
  task automatic step();
    repeat (HALF) @(negedge clk);
  endtask
  // styles: 0 A pulses, 1 B pulses, 2 A with B high, 3 A leads B, 4 B leads A
  always begin
    @(posedge clk iff go);
    busy = 1'b1;
    // pins move off the sampling edge
    @(negedge clk);
    b = (style == 3'h2);
    step();
    for (int i = 0; i < n; i++) begin
      if (style > 3'h2) begin
        {a, b} = (style == 3'h3) ? 2'b10 : 2'b01;
        step();
        {a, b} = 2'b11;
        step();
        {a, b} = (style == 3'h3) ? 2'b01 : 2'b10;
        step();
        {a, b} = 2'b00;
      end else begin
        if (style == 3'h1) b = 1'b1; else a = 1'b1;
        step();
        if (style == 3'h1) b = 1'b0; else a = 1'b0;
      end
      step();
    end
    b = 1'b0;
    busy = 1'b0;
  end
endmodule

// ===== test/quad_multimode_counter_tb_top.sv
// self-checking bench for the four-channel counter
`timescale 1ns/1ps
module quad_multimode_counter_tb_top;
  import counter_pkg::*;
  typedef struct {mode_e m; updown_e u; logic f; logic [31:0] p; logic [2:0] s;
    logic [7:0] k; logic [31:0] e;} row_s;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, busy, pa, pb, done_seen = 1'b0;
  logic ovf_seen = 1'b0, unf_seen = 1'b0;
  logic cfg_falling = 1'b0, cfg_wait_start = 1'b0;
  // all per-channel strobes in one word, so one task can pulse any of them
  logic [15:0] strb = '0;
  wire logic [3:0] cfg_full_wr = strb[3:0];
  wire logic [3:0] cfg_func_wr = strb[7:4];
  wire logic [3:0] cfg_avg_wr = strb[11:8];
  wire logic [3:0] cmd_valid = strb[15:12];
  logic [2:0] cfg_range = 3'h6, cfg_int_en = 3'h7, style = 3'h0;
  logic [7:0] n = 8'h0;
  logic [31:0] cfg_preset = '0;
  logic [15:0] cfg_average = 16'h0002;
  mode_e cfg_mode = MODE_TOTALIZE;
  updown_e cfg_updown = UD_SEPARATE;
  cmd_e cmd = CMD_NONE;
  logic [31:0] count_value [4], read_value [4], result_value [4];
  logic [3:0] result_fresh, running;
  logic [2:0] irq [4], range_read [4];
  mode_e mode_read [4];
  logic [15:0] average_read [4];
  int checked = 0, mismatches = 0, cycles = 0;
  row_s rows [10];
  always #4 clk = ~clk;
  pulse_source src (.clk(clk), .go(go), .style(style), .n(n), .a(pa), .b(pb), .busy(busy));
  quad_multimode_counter dut (.clk(clk), .rst(rst), .pin_a({4{pa}}), .pin_b({4{pb}}),
    .cfg_full_wr(cfg_full_wr), .cfg_func_wr(cfg_func_wr), .cfg_avg_wr(cfg_avg_wr),
    .cfg_mode(cfg_mode), .cfg_range(cfg_range), .cfg_updown(cfg_updown),
    .cfg_falling(cfg_falling), .cfg_wait_start(cfg_wait_start), .cfg_int_en(cfg_int_en),
    .cfg_preset(cfg_preset), .cfg_average(cfg_average), .cmd_valid(cmd_valid), .cmd(cmd),
    .count_value(count_value), .read_value(read_value), .result_value(result_value),
    .result_fresh(result_fresh), .running(running), .irq(irq), .mode_read(mode_read),
    .range_read(range_read), .average_read(average_read));
  task automatic conclude();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic strobe(input int sh);
    @(negedge clk);
    strb = 16'h1 << sh;
    @(negedge clk);
    strb = '0;
  endtask
  task automatic cfg(input mode_e m, input updown_e u, input logic [31:0] p, input logic f, w);
    cfg_mode = m;
    cfg_updown = u;
    cfg_preset = p;
    cfg_falling = f;
    cfg_wait_start = w;
    strobe(0);
  endtask
  task automatic command(input cmd_e c);
    cmd = c;
    strobe(12);
  endtask
  task automatic pulses(input logic [2:0] s, input logic [7:0] k);
    style = s;
    n = k;
    @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int i = 0; i < 4000 && busy; i++) @(negedge clk);
    if (busy === 1'b1) mismatches++;
    // leaves room for the synchroniser and edge latency
    repeat (8) @(negedge clk);
  endtask
  always @(negedge clk) begin
    cycles <= cycles + 1;
    if (irq[0][IRQ_DONE] === 1'b1) done_seen <= 1'b1;
    if (irq[0][IRQ_OVF] === 1'b1) ovf_seen <= 1'b1;
    if (irq[0][IRQ_UNF] === 1'b1) unf_seen <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rows = '{'{MODE_TOTALIZE, UD_SEPARATE, 1'b0, 32'h5, 3'h0, 8'h3, 32'h8},
      '{MODE_TOTALIZE, UD_SEPARATE, 1'b1, 32'h7fff, 3'h0, 8'h2, 32'h8001},
      '{MODE_TOTALIZE, UD_SEPARATE, 1'b0, 32'h0, 3'h1, 8'h2, 32'h0},
      '{MODE_UPDOWN, UD_SEPARATE, 1'b0, 32'h7ffe, 3'h0, 8'h2, 32'h0},
      '{MODE_UPDOWN, UD_SEPARATE, 1'b0, 32'h8001, 3'h1, 8'h2, 32'h0},
      '{MODE_UPDOWN, UD_DIRECTION, 1'b0, 32'h0, 3'h2, 8'h3, 32'hfffd},
      '{MODE_UPDOWN, UD_QUADRATURE, 1'b0, 32'h0, 3'h3, 8'h3, 32'h3},
      '{MODE_UPDOWN, UD_QUADRATURE, 1'b0, 32'h0, 3'h4, 8'h3, 32'hfffd},
      '{MODE_PRESCALE, UD_SEPARATE, 1'b0, 32'h3, 3'h0, 8'h5, 32'h1},
      '{MODE_EXTENDED, UD_SEPARATE, 1'b0, 32'h0, 3'h0, 8'h3, 32'h3}};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check(32'(mode_read[0]), 32'(MODE_TOTALIZE));
    check(32'(range_read[0]), 32'h1);
    check(32'(average_read[0]), 32'h1);
    check(32'(running), 32'h0);
    foreach (rows[i]) begin
      cfg(rows[i].m, rows[i].u, rows[i].p, rows[i].f, 1'b0);
      command(CMD_START);
      pulses(rows[i].s, rows[i].k);
      check(count_value[0], rows[i].e);
    end
    check(32'(ovf_seen), 32'h1);
    check(32'(unf_seen), 32'h1);
    for (int m = 0; m < 9; m++) begin
      cfg_mode = mode_e'(m);
      strobe(4);
      check(32'(mode_read[0]), 32'(m));
      check(32'(range_read[0]), 32'h6);
    end
    cfg_average = 16'h7fff;
    strobe(8);
    check(32'(average_read[0]), 32'h7fff);
    cfg_average = 16'h0002;
    cfg(MODE_TOTALIZE, UD_SEPARATE, 32'h10, 1'b0, 1'b0);
    command(CMD_START);
    pulses(3'h0, 8'h4);
    command(CMD_READ_RESTART);
    check(read_value[0], 32'h14);
    check(count_value[0], 32'h0);
    command(CMD_STOP);
    pulses(3'h0, 8'h2);
    check(count_value[0], 32'h0);
    command(CMD_CONTINUE);
    pulses(3'h0, 8'h2);
    check(count_value[0], 32'h2);
    // paced ratio: gate of two B cycles holds two A cycles
    cfg(MODE_RATIO, UD_SEPARATE, 32'h0, 1'b0, 1'b1);
    command(CMD_START);
    pulses(3'h3, 8'h4);
    check(result_value[0], 32'h2);
    check(32'(result_fresh[0]), 32'h1);
    check(32'(running[0]), 32'h0);
    check(32'(done_seen), 32'h1);
    // reset while stopped with a result held, then channel test mode counting internal 1 us ticks
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check(result_value[0], 32'h0);
    check(read_value[0], 32'h0);
    check(32'(result_fresh), 32'h0);
    check(32'(running), 32'h0);
    check(32'(mode_read[0]), 32'(MODE_TOTALIZE));
    cfg(MODE_TEST, UD_SEPARATE, 32'h0, 1'b0, 1'b0);
    command(CMD_START);
    // any 500 consecutive cycles hold exactly four 1 us ticks, whatever the phase
    repeat (500) @(negedge clk);
    check(count_value[0], 32'h4);
    conclude();
  end
endmodule
bind quad_multimode_counter counter_monitor mon (.clk(clk), .rst(rst),
  .cfg_full_wr(cfg_full_wr), .cfg_func_wr(cfg_func_wr), .cfg_mode(cfg_mode),
  .cmd_valid(cmd_valid), .cmd(cmd), .count_value(count_value), .read_value(read_value),
  .running(running), .mode_read(mode_read));
